/* File: logic/msb_pkg.sv */
package msb_pkg;
  // link timing
  localparam int unsigned LinkDiv = 25;  // ref_clk cycles per half link clock period
  // bus addresses
  localparam logic [6:0] DefaultAddr  = 7'h61;
  localparam logic [6:0] ArpAddr      = 7'h61;  // address used during resolution
  // commands (first data byte)
  localparam logic [7:0] CmdStatus     = 8'h01;
  localparam logic [7:0] CmdAssign     = 8'h02;
  localparam logic [7:0] CmdCounter    = 8'h03;
  localparam logic [7:0] CmdSetLink    = 8'h04;
  localparam logic [7:0] CmdArpDone    = 8'h05;
  // answer codes
  localparam logic [7:0] RespOk        = 8'h00;
  localparam logic [7:0] RespMediaConf = 8'h02;
  localparam logic [7:0] RespSpeedConf = 8'h05;
  localparam logic [7:0] RespFail      = 8'hee;
  // counter limits
  localparam logic [31:0] CntStop      = 32'h0ffffffe;
  localparam logic [31:0] CntUnsup     = 32'h0fffffff;
  // frame layout
  localparam int unsigned FrameBits    = 32;
endpackage

/* File: logic/msb_if.sv */
`timescale 1ns/10ps
interface msb_if;
  logic linkClk;
  logic hostData;
  logic devData;
  logic alertN;
  logic pauseFwd;
  modport dev  (input linkClk, input hostData, output devData, output alertN, output pauseFwd);
  modport host (output linkClk, output hostData, input devData, input alertN, input pauseFwd);
endinterface

/* File: logic/msb_device.sv */
`timescale 1ns/10ps
// Contract
// - no alert while in direct receive mode
// - controller polls status in direct receive
// - assigned address kept across power loss; reset here reloads ArpAddr or storeAddr instead
// - fixed address from nonvolatile store when resolution off
// - reject illegal addresses during resolution
// - bus dedicated to controller and device
// - pause frames forwarded; controller disables flow control
// - counters stop at all-ones-minus-one
// - controller reads counters before saturation
// - multiple speeds answered with media conflict
// - media conflict read as general error
module msb_device (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  msb_if.dev               link,
  // user side
  input  wire logic        directRx,
  input  wire logic        arpEnable,
  input  wire logic [6:0]  storeAddr,
  input  wire logic        statusEvent,
  input  wire logic        countEvent,
  input  wire logic        pauseRx,
  output logic [6:0]       curAddr,
  output logic [31:0]      counterVal
);
  // ==========================================
  // state
  typedef enum logic [1:0] {IDLE = 2'b00, RECV = 2'b01, SEND = 2'b11} st_t;
  typedef struct packed {
    logic [1:0]  clkSync;
    logic [1:0]  datSync;
    logic        clkPrev;
    st_t         st;
    logic [5:0]  bitCnt;
    logic [31:0] shIn;
    logic [31:0] shOut;
    logic        devData;
    logic        alertN;
    logic        pending;
    logic        pauseFwd;
    logic        arpDone;
    logic [6:0]  addr;
    logic [31:0] cnt;
    logic        loaded;
  } dev_t;
  dev_t s_ff, nxt_s;
  logic rise;
  logic [7:0] cmd;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.clkSync = {s_ff.clkSync[0], link.linkClk};
    nxt_s.datSync = {s_ff.datSync[0], link.hostData};
    nxt_s.clkPrev = s_ff.clkSync[1];
    rise = s_ff.clkSync[1] & ~s_ff.clkPrev;
    cmd  = s_ff.shIn[31:24];
    // address chosen after reset release; assigned one survives
    if (!s_ff.loaded) begin
      nxt_s.loaded = 1'b1;
      nxt_s.addr   = arpEnable ? msb_pkg::ArpAddr : storeAddr;
    end
    // saturating counter, reserved value never reached
    if (countEvent && s_ff.cnt < msb_pkg::CntStop) nxt_s.cnt = s_ff.cnt + 32'h1;
    // forward pause frames unchanged
    nxt_s.pauseFwd = pauseRx;
    // alert: sticky change, never raised in direct receive
    if (statusEvent) nxt_s.pending = 1'b1;
    nxt_s.alertN = ~(s_ff.pending & ~directRx);
    case (s_ff.st)
      IDLE: begin
        if (rise && s_ff.datSync[1]) begin  // start bit
          nxt_s.st = RECV;
          nxt_s.bitCnt = 6'h0;
        end
      end
      RECV: begin
        if (rise) begin
          nxt_s.shIn = {s_ff.shIn[30:0], s_ff.datSync[1]};
          nxt_s.bitCnt = s_ff.bitCnt + 6'h1;
          if (s_ff.bitCnt == 6'(msb_pkg::FrameBits - 1)) begin
            nxt_s.st = SEND;
            nxt_s.bitCnt = 6'h0;
          end
        end
      end
      SEND: begin
        if (s_ff.bitCnt == 6'h0 && !rise) begin
          nxt_s.shOut = answer(s_ff.shIn);
          nxt_s.bitCnt = 6'h1;
          if (s_ff.shIn[22:16] == s_ff.addr) begin
            if (cmd == msb_pkg::CmdStatus) nxt_s.pending = statusEvent;  // set wins
            if (cmd == msb_pkg::CmdAssign && assignOk(s_ff.shIn[6:0], s_ff.arpDone)) begin
              nxt_s.addr = s_ff.shIn[6:0];
            end
            if (cmd == msb_pkg::CmdArpDone) nxt_s.arpDone = 1'b1;
          end
        end else if (rise) begin
          nxt_s.devData = s_ff.shOut[31];
          nxt_s.shOut = {s_ff.shOut[30:0], 1'b0};
          nxt_s.bitCnt = s_ff.bitCnt + 6'h1;
          // last bit stays on the wire; the host samples it on the next rise, then stops its clock
          if (s_ff.bitCnt == 6'(msb_pkg::FrameBits)) begin
            nxt_s.st = IDLE;
          end
        end
      end
      default: nxt_s.st = IDLE;
    endcase
  end

  // legal: not reserved, not zero, only during resolution
  function automatic logic assignOk(input logic [6:0] a, input logic done);
    return !done && arpEnable && a != 7'h00 && a[6:3] != 4'hf && a != 7'h0c;
  endfunction

  // frame: cmd[31:24] addr[22:16] arg[15:0]; answer: code[31:24] data[23:0], except a counter read, which returns the count in all 32 bits
  function automatic logic [31:0] answer(input logic [31:0] f);
    logic [7:0] c;
    c = f[31:24];
    if (f[22:16] != s_ff.addr) return 32'h0;
    case (c)
      msb_pkg::CmdStatus:  return {msb_pkg::RespOk, 16'h0, 7'h0, s_ff.pending};  // polled
      msb_pkg::CmdCounter: return s_ff.cnt;
      msb_pkg::CmdSetLink: begin
        // more than one forced speed gives media conflict
        if ($countones(f[2:0]) > 1) return {msb_pkg::RespMediaConf, 24'h0};
        return {msb_pkg::RespOk, 24'h0};
      end
      msb_pkg::CmdAssign:
        return {(assignOk(f[6:0], s_ff.arpDone) ? msb_pkg::RespOk : msb_pkg::RespFail), 24'h0};
      msb_pkg::CmdArpDone: return {(arpEnable ? msb_pkg::RespOk : msb_pkg::RespFail), 24'h0};
      default: return {msb_pkg::RespFail, 24'h0};
    endcase
  endfunction

  // ==========================================
  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '{st: IDLE, alertN: 1'b1, addr: msb_pkg::DefaultAddr, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.devData  = s_ff.devData;
  assign link.alertN   = s_ff.alertN;
  assign link.pauseFwd = s_ff.pauseFwd;
  assign curAddr       = s_ff.addr;
  assign counterVal    = s_ff.cnt;
endmodule

/* File: logic/msb_host.sv */
`timescale 1ns/10ps
module msb_host (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // link
  msb_if.host              link,
  // user side
  input  wire logic        reqValid,
  input  wire logic [31:0] reqFrame,
  output logic             busy,
  output logic             rspValid,
  output logic [31:0]      rspFrame,
  output logic             alertSeen,
  output logic             pauseSeen
);
  // ==========================================
  // state
  typedef enum logic [1:0] {IDLE = 2'b00, SEND = 2'b01, RECV = 2'b11} st_t;
  typedef struct packed {
    st_t         st;
    logic [7:0]  div;
    logic        clk;
    logic [6:0]  bitCnt;
    logic [32:0] sh;
    logic [31:0] rsp;
    logic        data;
    logic        rspValid;
    logic [1:0]  alertSync;
    logic [1:0]  pauseSync;
    logic [1:0]  datSync;
  } host_t;
  host_t s_ff, nxt_s;
  logic fall, rise;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rspValid = 1'b0;
    nxt_s.alertSync = {s_ff.alertSync[0], ~link.alertN};
    nxt_s.pauseSync = {s_ff.pauseSync[0], link.pauseFwd};  // flow control stays off
    nxt_s.datSync = {s_ff.datSync[0], link.devData};
    fall = 1'b0;
    rise = 1'b0;
    // link clock divider, runs only during a frame
    if (s_ff.st != IDLE) begin
      nxt_s.div = s_ff.div + 8'h1;
      if (s_ff.div == 8'(msb_pkg::LinkDiv - 1)) begin
        nxt_s.div = 8'h0;
        nxt_s.clk = ~s_ff.clk;
        rise = ~s_ff.clk;
        fall = s_ff.clk;
      end
    end
    case (s_ff.st)
      IDLE: begin
        if (reqValid) begin
          nxt_s.st = SEND;
          nxt_s.sh = {1'b1, reqFrame};  // start bit then frame
          nxt_s.data = 1'b1;
          nxt_s.bitCnt = 7'h0;
        end
      end
      SEND: begin
        if (fall) begin
          nxt_s.sh = {s_ff.sh[31:0], 1'b0};
          nxt_s.data = s_ff.sh[31];
          nxt_s.bitCnt = s_ff.bitCnt + 7'h1;
          if (s_ff.bitCnt == 7'(msb_pkg::FrameBits)) begin
            nxt_s.st = RECV;
            nxt_s.data = 1'b0;
            nxt_s.bitCnt = 7'h0;
          end
        end
      end
      RECV: begin
        // media conflict code is passed up unchanged in rspFrame
        if (rise) begin
          nxt_s.bitCnt = s_ff.bitCnt + 7'h1;
          if (s_ff.bitCnt != 7'h0) nxt_s.rsp = {s_ff.rsp[30:0], s_ff.datSync[1]};
          // rise zero is skipped, rises one to thirty-two carry the answer bits
          if (s_ff.bitCnt == 7'(msb_pkg::FrameBits)) begin
            nxt_s.st = IDLE;
            nxt_s.clk = 1'b0;
            nxt_s.div = 8'h0;
            nxt_s.rspValid = 1'b1;
          end
        end
      end
      default: nxt_s.st = IDLE;
    endcase
  end

  // ==========================================
  // registers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      s_ff <= '{st: IDLE, default: '0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign link.linkClk  = s_ff.clk;
  assign link.hostData = s_ff.data;
  assign busy          = s_ff.st != IDLE;
  assign rspValid      = s_ff.rspValid;
  assign rspFrame      = s_ff.rsp;
  assign alertSeen     = s_ff.alertSync[1];
  assign pauseSeen     = s_ff.pauseSync[1];
endmodule

/* File: tb/msb_props.sv */
`timescale 1ns/10ps
module msb_props (
  // clock and reset
  input wire logic        ref_clk,
  input wire logic        rst,
  // link wires
  input wire logic        alertN,
  input wire logic        pauseFwd,
  // device user side
  input wire logic        directRx,
  input wire logic        arpEnable,
  input wire logic        pauseRx,
  input wire logic [6:0]  storeAddr,
  input wire logic [6:0]  curAddr,
  input wire logic [31:0] counterVal
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // ====
  // wire checks
  a_alert_quiet: assert property (directRx && $past(directRx) && $past(directRx, 2) |-> alertN)
    else $error("alert low in direct receive");
  a_pause_fwd: assert property (pauseRx |-> ##[1:8] pauseFwd)
    else $error("pause frame not forwarded");
  // ====
  // device state checks; the two address-source checks skip the first two edges while the address loads
  a_count_cap: assert property (counterVal <= msb_pkg::CntStop)
    else $error("counter beyond stop value");
  a_addr_legal: assert property (curAddr != 7'h00 && curAddr != 7'h0c && curAddr < 7'h78)
    else $error("illegal address taken");
  a_fixed_addr: assert property (!arpEnable && !$past(rst) && !$past(rst, 2) |-> curAddr == storeAddr)
    else $error("fixed address not used");
  a_addr_kept: assert property ($changed(curAddr) && !$past(rst) && !$past(rst, 2) |-> arpEnable)
    else $error("address changed outside resolution");
endmodule

/* File: tb/manageability_sideband_port_tb_top.sv */
`timescale 1ns/10ps
module manageability_sideband_port_tb_top;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        directRx = 1'b0, arpEnable = 1'b0, statusEvent = 1'b0, countEvent = 1'b0, pauseRx = 1'b0;
  logic        reqValid = 1'b0;
  logic [31:0] reqFrame = 32'h0, rsp, counterVal, rspFrame;
  logic [6:0]  storeAddr = 7'h2a, curAddr;
  logic        busy, rspValid, alertSeen, pauseSeen;
  int          fail_count = 0, compares = 0;
  // ====
  // clock and the two ends; one device alone on the segment
  always #2.5 ref_clk = ~ref_clk;
  msb_if msb_if_inst ();
  msb_device msb_device_inst (.ref_clk(ref_clk), .rst(rst), .link(msb_if_inst.dev), .directRx(directRx),
    .arpEnable(arpEnable), .storeAddr(storeAddr), .statusEvent(statusEvent), .countEvent(countEvent),
    .pauseRx(pauseRx), .curAddr(curAddr), .counterVal(counterVal));
  msb_host msb_host_inst (.ref_clk(ref_clk), .rst(rst), .link(msb_if_inst.host), .reqValid(reqValid),
    .reqFrame(reqFrame), .busy(busy), .rspValid(rspValid), .rspFrame(rspFrame), .alertSeen(alertSeen),
    .pauseSeen(pauseSeen));
  msb_props msb_props_inst (.ref_clk(ref_clk), .rst(rst), .alertN(msb_if_inst.alertN),
    .pauseFwd(msb_if_inst.pauseFwd), .directRx(directRx), .arpEnable(arpEnable), .pauseRx(pauseRx),
    .storeAddr(storeAddr), .curAddr(curAddr), .counterVal(counterVal));
  // ====
  // tasks; all that wait return 1 ns after an edge, cmp takes no time and end_sim never returns
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic restart(input logic arp, input logic [6:0] a);
    rst = 1'b1;
    arpEnable = arp;
    storeAddr = a;
    tick(8);
    rst = 1'b0;
    tick(3);
  endtask
  // a frame is long, so the wait bound covers one frame with margin
  task automatic xfer(input logic [7:0] c, input logic [6:0] a, input logic [15:0] g);
    int n;
    n = 0;
    reqFrame = {c, 1'b0, a, g};
    reqValid = 1'b1;
    tick(1);
    reqValid = 1'b0;
    while (rspValid !== 1'b1 && n < 5000) begin
      tick(1);
      n++;
    end
    if (n == 5000) begin
      fail_count++;
      end_sim();
    end
    rsp = rspFrame;
  endtask
  task automatic code(input logic [7:0] c, input logic [6:0] a, input logic [15:0] g, input logic [7:0] e);
    xfer(c, a, g);
    cmp("code", {24'h0, e}, {24'h0, rsp[31:24]});
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
    tick(1);
  endtask
  // ====
  // watchdog, sized for about twenty-four frames
  initial begin
    #400000;
    fail_count++;
    end_sim();
  end
  // ====
  // main sequence
  initial begin
    restart(1'b0, 7'h2a);
    cmp("addr", 32'h2a, {25'h0, curAddr});
    code(msb_pkg::CmdStatus, 7'h2a, 16'h0, msb_pkg::RespOk);
    xfer(msb_pkg::CmdStatus, 7'h15, 16'h0);
    cmp("foreign", 32'h0, rsp);
    code(msb_pkg::CmdAssign, 7'h2a, 16'h33, msb_pkg::RespFail);
    code(msb_pkg::CmdSetLink, 7'h2a, 16'h3, msb_pkg::RespMediaConf);
    code(msb_pkg::CmdSetLink, 7'h2a, 16'h4, msb_pkg::RespOk);
    directRx = 1'b1;
    pulse(statusEvent);
    tick(10);
    cmp("alert", 32'h0, {31'h0, alertSeen});
    code(msb_pkg::CmdStatus, 7'h2a, 16'h0, msb_pkg::RespOk);
    directRx = 1'b0;
    pulse(statusEvent);
    tick(10);
    cmp("alert", 32'h1, {31'h0, alertSeen});
    code(msb_pkg::CmdStatus, 7'h2a, 16'h0, msb_pkg::RespOk);
    tick(10);
    cmp("alert", 32'h0, {31'h0, alertSeen});
    pauseRx = 1'b1;
    tick(10);
    cmp("pause", 32'h1, {31'h0, pauseSeen});
    pauseRx = 1'b0;
    repeat (5) pulse(countEvent);
    xfer(msb_pkg::CmdCounter, 7'h2a, 16'h0);
    cmp("count", 32'h5, rsp);
    // second run with resolution on
    restart(1'b1, 7'h2a);
    cmp("addr", {25'h0, msb_pkg::ArpAddr}, {25'h0, curAddr});
    code(msb_pkg::CmdAssign, msb_pkg::ArpAddr, 16'hc, msb_pkg::RespFail);
    code(msb_pkg::CmdAssign, msb_pkg::ArpAddr, 16'h7a, msb_pkg::RespFail);
    code(msb_pkg::CmdAssign, msb_pkg::ArpAddr, 16'h33, msb_pkg::RespOk);
    code(msb_pkg::CmdArpDone, 7'h33, 16'h0, msb_pkg::RespOk);
    code(msb_pkg::CmdAssign, 7'h33, 16'h44, msb_pkg::RespFail);
    code(msb_pkg::CmdStatus, 7'h33, 16'h0, msb_pkg::RespOk);
    cmp("addr", 32'h33, {25'h0, curAddr});
    end_sim();
  end
endmodule
